// File: dma_global_control_crc.sv
// Purpose: global run control, last-access status, crc generator and channel irq bits
// Assumes: channel engine on the same clock reports each bus beat and block end
// Notes:   the channel engine must honour DMA_RUN and DEST_WR_SUPPRESS
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps

// Function
// - module enable gates all dma activity
// - debug freeze halts dma in debug
// - freeze writable only in debug exception
// - stop-in-idle freezes transfers during sleep
// - suspend halts dma for cpu bus
// - status shows last access direction
// - status shows last active channel
// - last access address, reset zero
// - length field sets active crc width
// - crc enable routes selected channel
// - append mode feeds crc, suppresses write
// - append writes crc at block end
// - normal mode transfers and accumulates crc
// - two-bit field selects crc channel
// - crc value write seeds generator
// - crc value read returns crc
// - bits above length read zero
// - mask bits enable stage feedback xor
// - mask low bit always reads one
module dma_global_control_crc (
    input  wire logic                            SYS_CLK,
    input  wire logic                            RST_B,
    // register port
    input  wire logic [31:0]                     REG_ADDR,
    input  wire logic [31:0]                     REG_WDATA,
    input  wire logic                            REG_WR,
    input  wire logic                            REG_RD,
    output logic      [31:0]                     REG_RDATA,
    // processor mode
    input  wire logic                            DEBUG_MODE,
    input  wire logic                            DEBUG_EXC,
    input  wire logic                            SLEEP_MODE,
    // channel engine beats
    input  wire logic                            XFER_VALID,
    input  wire logic [dma_gc_pkg::CH_W-1:0]     XFER_CH,
    input  wire logic                            XFER_IS_READ,
    input  wire logic [31:0]                     XFER_ADDR,
    input  wire logic [dma_gc_pkg::BYTE_W-1:0]   XFER_DATA,
    input  wire logic                            BLOCK_DONE,
    input  wire logic [dma_gc_pkg::CH_W-1:0]     BLOCK_DONE_CH,
    input  wire logic [dma_gc_pkg::NUM_CH-1:0]   CH_IRQ_EVENT,
    // control back to the engine
    output logic                                 DMA_RUN,
    output logic                                 DEST_WR_SUPPRESS,
    output logic                                 APPEND_WR,
    output logic      [dma_gc_pkg::CRC_W-1:0]    APPEND_DATA,
    output logic      [dma_gc_pkg::NUM_CH-1:0]   IRQ_REQ,
    output logic      [dma_gc_pkg::PRI_W-1:0]    CH3_IRQ_PRI,
    output logic      [dma_gc_pkg::SUB_W-1:0]    CH3_IRQ_SUB
);
    import dma_gc_pkg::*;

    // ==========================================================
    // functions
    // ones in the active crc width; width is length field plus one
    // the shift is done one bit wider so a full-width length does not wrap to zero
    function automatic logic [CRC_W-1:0] len_mask(input logic [LEN_W-1:0] len_m1);
        logic [CRC_W:0] t;
        t = {{CRC_W{1'b0}}, 1'b1} << ({1'b0, len_m1} + 5'h1);
        return t[CRC_W-1:0] - {{(CRC_W-1){1'b0}}, 1'b1};
    endfunction : len_mask

    // fold one data byte, msb first, into the galois shift register
    // bits above the active width may pick up junk inside the loop; they are
    // never read by the feedback tap and are cut off at the end
    function automatic logic [CRC_W-1:0] crc_byte(input logic [CRC_W-1:0]  c_in,
                                                  input logic [CRC_W-1:0]  mask,
                                                  input logic [LEN_W-1:0]  len_m1,
                                                  input logic [BYTE_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic             fb;
        c = c_in;
        for (int i = BYTE_W - 1; i >= 0; i--) begin
            fb = d[i] ^ c[len_m1];
            c  = {c[CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ mask;
            end
        end
        return c & len_mask(len_m1);
    endfunction : crc_byte

    // ==========================================================
    // reset release
    logic [SYNC_W-1:0] rst_sync_q; // release shift chain
    logic              rst_n;      // synchronised reset for the rest

    // assert at once, release two edges later
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[SYNC_W-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[SYNC_W-1];

    // ==========================================================
    // register decode
    logic                     on_q, freeze_q, idle_stop_q;      // global control bits
    logic                     susp_q;                           // suspend bit
    logic                     last_dir_q;                       // last access was a read
    logic [CH_W-1:0]          last_ch_q;                        // last active channel
    logic [31:0]              last_addr_q;                      // last access address
    logic [LEN_W-1:0]         len_m1_q;                         // length minus one
    logic                     crc_en_q, app_q;                  // crc route and append
    logic [CH_W-1:0]          csel_q;                           // crc channel
    logic [CRC_W-1:0]         crc_q;                            // crc shift register
    logic [CRC_W-1:0]         mask_q;                           // feedback mask
    logic [NUM_CH-1:0]        irq_flag_q, irq_en_q;             // channel irq bits
    logic [PRI_W-1:0]         pri_q;                            // channel 3 priority
    logic [SUB_W-1:0]         sub_q;                            // channel 3 subpriority
    logic                     wr_gctrl, wr_crccon, wr_crcval;   // write selects
    logic                     wr_mask, wr_flag, wr_en, wr_pri;
    logic                     xfer_take;                        // beat counted while running
    logic                     crc_on_ch, crc_feed, append_done; // crc attach terms
    logic [31:0]              rd_mux;                           // read data before its flop

    assign wr_gctrl  = REG_WR && (REG_ADDR == ADDR_GCTRL);
    assign wr_crccon = REG_WR && (REG_ADDR == ADDR_CRCCON);
    assign wr_crcval = REG_WR && (REG_ADDR == ADDR_CRCVAL);
    assign wr_mask   = REG_WR && (REG_ADDR == ADDR_CRCMASK);
    assign wr_flag   = REG_WR && (REG_ADDR == ADDR_IRQ_FLAG);
    assign wr_en     = REG_WR && (REG_ADDR == ADDR_IRQ_EN);
    assign wr_pri    = REG_WR && (REG_ADDR == ADDR_IRQ_PRI);

    // ==========================================================
    // global control
    // reserved bits are simply not stored, so whatever software writes there is lost
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            on_q        <= 1'b0;
            idle_stop_q <= 1'b0;
            susp_q      <= 1'b0;
        end else if (wr_gctrl) begin
            on_q        <= REG_WDATA[ON_BIT];
            idle_stop_q <= REG_WDATA[IDLE_STOP_BIT];
            susp_q      <= REG_WDATA[SUSP_BIT];
        end
    end

    // freeze bit: takes writes only in debug exception, held clear otherwise
    // clearing every cycle, not only on write, means leaving debug drops it at once
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            freeze_q <= 1'b0;
        end else if (!DEBUG_EXC) begin
            freeze_q <= 1'b0;
        end else if (wr_gctrl) begin
            freeze_q <= REG_WDATA[FREEZE_BIT];
        end
    end

    // run permission seen by the channel engine
    // kept combinational so a freeze or suspend stops the very next beat
    assign DMA_RUN = on_q
                     && !(freeze_q && DEBUG_MODE)
                     && !(idle_stop_q && SLEEP_MODE)
                     && !susp_q;

    // ==========================================================
    // last access status
    assign xfer_take = XFER_VALID && DMA_RUN;

    // beats offered while frozen are not real bus accesses, so they leave status alone
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            last_dir_q  <= 1'b0;
            last_ch_q   <= '0;
            last_addr_q <= ZERO32;
        end else if (xfer_take) begin
            last_dir_q  <= XFER_IS_READ;
            last_ch_q   <= XFER_CH;
            last_addr_q <= XFER_ADDR;
        end
    end

    // ==========================================================
    // crc control
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            len_m1_q <= '0;
            crc_en_q <= 1'b0;
            app_q    <= 1'b0;
            csel_q   <= '0;
        end else if (wr_crccon) begin
            len_m1_q <= REG_WDATA[LEN_LO +: LEN_W];
            crc_en_q <= REG_WDATA[CRC_ON_BIT];
            app_q    <= REG_WDATA[APP_BIT];
            csel_q   <= REG_WDATA[CSEL_LO +: CH_W];
        end
    end

    // feedback mask; low bit cannot be cleared
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RST;
        end else if (wr_mask) begin
            mask_q <= REG_WDATA[CRC_W-1:0] | MASK_RST;
        end
    end

    assign crc_on_ch   = crc_en_q && (XFER_CH == csel_q);
    assign crc_feed    = xfer_take && XFER_IS_READ && crc_on_ch;
    assign append_done = BLOCK_DONE && crc_en_q && app_q && (BLOCK_DONE_CH == csel_q);
    // append mode: the engine drops destination writes of the crc channel
    assign DEST_WR_SUPPRESS = crc_on_ch && app_q;

    // crc register: a seed write beats a beat in the same cycle
    // a length change trims the stored value too, so the register never holds
    // bits above the active width; widening again shows zeros, not old bits
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= '0;
        end else if (wr_crcval) begin
            crc_q <= REG_WDATA[CRC_W-1:0] & len_mask(len_m1_q);
        end else if (wr_crccon) begin
            crc_q <= crc_q & len_mask(REG_WDATA[LEN_LO +: LEN_W]);
        end else if (crc_feed) begin
            crc_q <= crc_byte(crc_q, mask_q, len_m1_q, XFER_DATA);
        end
    end

    // block end in append mode: hand the crc to the engine for the destination start
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            APPEND_WR   <= 1'b0;
            APPEND_DATA <= '0;
        end else begin
            APPEND_WR <= append_done;
            if (append_done) begin
                APPEND_DATA <= crc_q & len_mask(len_m1_q);
            end
        end
    end

    // ==========================================================
    // channel interrupt bits
    // hardware events win over a software clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_q <= '0;
        end else if (wr_flag) begin
            irq_flag_q <= REG_WDATA[IRQ_LO +: NUM_CH] | CH_IRQ_EVENT;
        end else begin
            irq_flag_q <= irq_flag_q | CH_IRQ_EVENT;
        end
    end

    // enables and channel 3 priority fields
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= '0;
            pri_q    <= '0;
            sub_q    <= '0;
        end else begin
            if (wr_en) begin
                irq_en_q <= REG_WDATA[IRQ_LO +: NUM_CH];
            end
            if (wr_pri) begin
                pri_q <= REG_WDATA[PRI_LO +: PRI_W];
                sub_q <= REG_WDATA[SUB_LO +: SUB_W];
            end
        end
    end

    assign IRQ_REQ     = irq_flag_q & irq_en_q;
    assign CH3_IRQ_PRI = pri_q;
    assign CH3_IRQ_SUB = sub_q;

    // ==========================================================
    // read path
    // unmapped addresses read zero
    always_comb begin
        rd_mux = ZERO32;
        unique case (REG_ADDR)
            ADDR_GCTRL: begin
                rd_mux[ON_BIT]   = on_q;
                rd_mux[FREEZE_BIT]    = freeze_q;
                rd_mux[IDLE_STOP_BIT] = idle_stop_q;
                rd_mux[SUSP_BIT] = susp_q;
            end
            ADDR_GSTAT: begin
                rd_mux[DIR_BIT]           = last_dir_q;
                rd_mux[LCH_LO +: CH_W]    = last_ch_q;
            end
            ADDR_LADDR:    rd_mux = last_addr_q;
            ADDR_CRCCON: begin
                rd_mux[LEN_LO +: LEN_W]   = len_m1_q;
                rd_mux[CRC_ON_BIT]        = crc_en_q;
                rd_mux[APP_BIT]           = app_q;
                rd_mux[CSEL_LO +: CH_W]   = csel_q;
            end
            ADDR_CRCVAL:   rd_mux[CRC_W-1:0] = crc_q & len_mask(len_m1_q);
            ADDR_CRCMASK:  rd_mux[CRC_W-1:0] = mask_q;
            ADDR_IRQ_FLAG: rd_mux[IRQ_LO +: NUM_CH] = irq_flag_q;
            ADDR_IRQ_EN:   rd_mux[IRQ_LO +: NUM_CH] = irq_en_q;
            ADDR_IRQ_PRI: begin
                rd_mux[PRI_LO +: PRI_W] = pri_q;
                rd_mux[SUB_LO +: SUB_W] = sub_q;
            end
            default:       rd_mux = ZERO32;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= ZERO32;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : ZERO32;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence append_end_s;
        BLOCK_DONE && crc_en_q && app_q && (BLOCK_DONE_CH == csel_q);
    endsequence
    sequence append_out_s;
        APPEND_WR && (APPEND_DATA == ($past(crc_q) & len_mask($past(len_m1_q))));
    endsequence

    module_off_a: assert property (!on_q |-> !DMA_RUN)
        else $error("dma runs while module disabled");
    debug_freeze_a: assert property (freeze_q && DEBUG_MODE |-> !DMA_RUN)
        else $error("dma runs while frozen in debug");
    freeze_normal_a: assert property (!DEBUG_EXC ##1 1 |-> !freeze_q)
        else $error("freeze bit set outside debug exception");
    idle_stop_a: assert property (idle_stop_q && SLEEP_MODE |-> !DMA_RUN)
        else $error("dma runs during sleep with stop in idle");
    suspend_hold_a: assert property (susp_q |-> !DMA_RUN)
        else $error("dma runs while suspended");
    status_capture_a: assert property (xfer_take |=>
        last_dir_q == $past(XFER_IS_READ) && last_ch_q == $past(XFER_CH))
        else $error("status not captured from last beat");
    addr_capture_a: assert property (xfer_take |=> last_addr_q == $past(XFER_ADDR))
        else $error("last address not captured");
    append_suppress_a: assert property (crc_en_q && app_q && XFER_CH == csel_q
        |-> DEST_WR_SUPPRESS)
        else $error("append mode write not suppressed");
    append_write_a: assert property (append_end_s |=> append_out_s)
        else $error("append crc not written at block end");
    // the stored value, not only the read view, stays inside the active width
    crc_width_a: assert property ((crc_q & ~len_mask(len_m1_q)) == '0
        || $changed(len_m1_q))
        else $error("crc bits above length are set");
    crc_seed_a: assert property (wr_crcval |=>
        crc_q == ($past(REG_WDATA[CRC_W-1:0]) & len_mask($past(len_m1_q))))
        else $error("crc seed not loaded");
    mask_low_a: assert property (mask_q[0])
        else $error("crc mask low bit clear");
    irq_raise_a: assert property (|(CH_IRQ_EVENT & irq_en_q) && !wr_en |=> |IRQ_REQ)
        else $error("enabled channel event gave no request");

endmodule : dma_global_control_crc

// File: dma_gc_pkg.sv
// Purpose: shared constants for the dma global control, status and crc block
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes:   fields sit at fixed bit positions; unlisted bits read as zero
package dma_gc_pkg;

    // ==========================================================
    // register byte addresses
    localparam logic [31:0] ADDR_IRQ_FLAG = 32'hbf881040; // channel irq flags
    localparam logic [31:0] ADDR_IRQ_EN   = 32'hbf881070; // channel irq enables
    localparam logic [31:0] ADDR_IRQ_PRI  = 32'hbf881120; // channel 3 priority
    localparam logic [31:0] ADDR_GCTRL    = 32'hbf883000; // global control
    localparam logic [31:0] ADDR_GSTAT    = 32'hbf883010; // global status
    localparam logic [31:0] ADDR_LADDR    = 32'hbf883020; // last access address
    localparam logic [31:0] ADDR_CRCCON   = 32'hbf883030; // crc control
    localparam logic [31:0] ADDR_CRCVAL   = 32'hbf883040; // crc value
    localparam logic [31:0] ADDR_CRCMASK  = 32'hbf883050; // crc feedback mask

    // ==========================================================
    // widths
    localparam int NUM_CH = 4;  // channels
    localparam int CH_W   = 2;  // channel number width
    localparam int CRC_W  = 16; // crc shift register width
    localparam int LEN_W  = 4;  // polynomial length field width
    localparam int PRI_W  = 3;  // irq priority width
    localparam int SUB_W  = 2;  // irq subpriority width
    localparam int BYTE_W = 8;  // data bits folded into the crc per beat
    localparam int SYNC_W = 2;  // reset release stages

    // ==========================================================
    // field positions
    localparam int ON_BIT    = 15; // module enable
    localparam int FREEZE_BIT    = 14; // debug freeze
    localparam int IDLE_STOP_BIT = 13; // stop in idle
    localparam int SUSP_BIT  = 12; // suspend
    localparam int DIR_BIT   = 3;  // last access direction
    localparam int LCH_LO    = 0;  // last active channel
    localparam int LEN_LO     = 8;  // polynomial length minus one
    localparam int CRC_ON_BIT = 7;  // crc route enable
    localparam int APP_BIT   = 6;  // crc append mode
    localparam int CSEL_LO   = 0;  // crc channel select
    localparam int IRQ_LO    = 16; // per-channel irq flag/enable base
    localparam int PRI_LO    = 26; // channel 3 priority
    localparam int SUB_LO    = 24; // channel 3 subpriority

    // ==========================================================
    // reset values
    localparam logic [31:0]      ZERO32   = 32'h0000_0000;
    localparam logic [CRC_W-1:0] MASK_RST = 16'h0001; // low mask bit is always set

endpackage : dma_gc_pkg

// File: engine_model.sv
// Purpose: channel engine stand-in issuing bus beats to the block
// Assumes: same clock as the block; one beat is a one-cycle pulse
// Notes:   idle lines flip so a stale beat is never mistaken for a live one
`timescale 1ns/10ps
module engine_model (
    input  wire logic        clk,
    output logic             valid,
    output logic [1:0]       ch,
    output logic             is_rd,
    output logic [31:0]      addr,
    output logic [7:0]       data
);
    // ==========================================
    // quiet lines at time zero
    initial {valid, ch, is_rd, addr, data} = '0;

    // one beat after gap idle cycles, so answers come promptly or slowly
    task automatic beat(input int gap, input logic [1:0] c, input logic r,
                        input logic [31:0] a, input logic [7:0] d);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        valid <= 1'b1;
        {ch, is_rd, addr, data} <= {c, r, a, d};
        @(posedge clk);
        valid <= 1'b0;
        // released lines show the inverse, not the last value
        {ch, is_rd, addr, data} <= ~{c, r, a, d};
    endtask : beat
endmodule : engine_model

// File: testbench.sv
// Purpose: self-checking bench for the dma global control and crc block
// Assumes: register port with read data in the cycle after the strobe
// Notes:   expectations come from bench functions, never from the block
`timescale 1ns/10ps
module testbench;
    import dma_gc_pkg::*;
    logic        clk, rst_b, wr, rd, dbg, dexc, slp, bd, run, sup, awr;
    logic        xv, xrd;
    logic [31:0] addr, wdat, rdat, xa;
    logic [1:0]  xch, bdch, sub;
    logic [7:0]  xd;
    logic [3:0]  ev, irq;
    logic [2:0]  pri;
    logic [15:0] adat, crc_m, msk;
    int          error_cnt, samples_checked;

    dma_global_control_crc DUT (.SYS_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
        .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .DEBUG_MODE(dbg), .DEBUG_EXC(dexc), .SLEEP_MODE(slp), .XFER_VALID(xv),
        .XFER_CH(xch), .XFER_IS_READ(xrd), .XFER_ADDR(xa), .XFER_DATA(xd),
        .BLOCK_DONE(bd), .BLOCK_DONE_CH(bdch), .CH_IRQ_EVENT(ev), .DMA_RUN(run),
        .DEST_WR_SUPPRESS(sup), .APPEND_WR(awr), .APPEND_DATA(adat),
        .IRQ_REQ(irq), .CH3_IRQ_PRI(pri), .CH3_IRQ_SUB(sub));
    engine_model eng (.clk(clk), .valid(xv), .ch(xch), .is_rd(xrd), .addr(xa),
        .data(xd));

    // ==========================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // ==========================================
    // shared tasks and models
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat, e);
    endtask : rreg
    // block end pulse on channel c, append write expected or not
    task automatic blk(input logic [1:0] c, input logic e);
        @(posedge clk);
        bd <= 1'b1;
        bdch <= c;
        @(posedge clk);
        bd <= 1'b0;
        #1;
        chk(32'(awr), 32'(e));
    endtask : blk
    function automatic logic [15:0] lm(input int l);
        return 16'((17'h1 << (l + 1)) - 17'h1);
    endfunction : lm
    // msb-first galois step over one byte, kept to the active width
    function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] m,
                                         input int l, input logic [7:0] d);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = d[i] ^ c[l];
            c = c << 1;
            if (fb) c = c ^ m;
        end
        return c & lm(l);
    endfunction : step
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] r, r2, ad;
        logic [1:0]  sel, c;
        int          pl;
        {wr, rd, dbg, dexc, slp, bd, addr, wdat, bdch, ev} = '0;
        rst_b = 1'b0;
        r = $urandom(89281);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rreg(ADDR_GCTRL, 32'h0);
        rreg(ADDR_LADDR, 32'h0);
        rreg(ADDR_CRCMASK, 32'h1);
        rreg(32'hbf883060, 32'h0);
        // freeze only sticks in debug exception; reserved bits drop
        wreg(ADDR_GCTRL, 32'hffff_ffff);
        rreg(ADDR_GCTRL, 32'h0000_b000);
        dexc <= 1'b1;
        wreg(ADDR_GCTRL, 32'hffff_ffff);
        rreg(ADDR_GCTRL, 32'h0000_f000);
        repeat (16) begin
            r = $urandom;
            wreg(ADDR_GCTRL, {16'h0, r[3:0], 12'h0});
            dbg <= r[4];
            slp <= r[5];
            @(posedge clk);
            #1;
            chk(32'(run), 32'(r[3] & !(r[2] & r[4]) & !(r[1] & r[5]) & !r[0]));
        end
        dexc <= 1'b0;
        rreg(ADDR_GCTRL, {16'h0, r[3], 1'b0, r[1:0], 12'h0});
        dbg <= 1'b0;
        slp <= 1'b0;
        wreg(ADDR_GCTRL, 32'h8000);
        repeat (8) begin
            r = $urandom;
            ad = $urandom;
            eng.beat(int'(r[1:0]), r[3:2], r[4], ad, r[15:8]);
            rreg(ADDR_GSTAT, {28'h0, r[4], 1'b0, r[3:2]});
            rreg(ADDR_LADDR, ad);
        end
        // suspended beats leave the status alone
        wreg(ADDR_GCTRL, 32'h9000);
        eng.beat(0, ~r[3:2], ~r[4], ~ad, 8'h0);
        rreg(ADDR_LADDR, ad);
        wreg(ADDR_GCTRL, 32'h8000);
        repeat (6) begin
            r = $urandom;
            pl = int'(r[11:8]);
            sel = r[1:0];
            r2 = $urandom;
            msk = r2[15:0] | 16'h1;
            wreg(ADDR_CRCMASK, {16'h0, r2[15:0]});
            rreg(ADDR_CRCMASK, {16'h0, msk});
            wreg(ADDR_CRCCON, {20'h0, r[11:8], 6'h20, sel});
            rreg(ADDR_CRCCON, {20'h0, r[11:8], 6'h20, sel});
            wreg(ADDR_CRCVAL, r2 & 32'hffff);
            crc_m = r2[15:0] & lm(pl);
            rreg(ADDR_CRCVAL, {16'h0, crc_m});
            repeat (6) begin
                r2 = $urandom;
                c = r2[9] ? sel : r2[1:0];
                eng.beat(int'(r2[3:2]), c, r2[8], r2, r2[31:24]);
                if (r2[8] && c == sel) crc_m = step(crc_m, msk, pl, r2[31:24]);
            end
            rreg(ADDR_CRCVAL, {16'h0, crc_m});
        end
        // append mode: read data folds in, result goes out at block end
        wreg(ADDR_CRCCON, {20'h0, 4'hf, 6'h30, sel});
        r = $urandom;
        wreg(ADDR_CRCVAL, r);
        crc_m = r[15:0];
        eng.beat(0, sel, 1'b1, r, r[7:0]);
        crc_m = step(crc_m, msk, 15, r[7:0]);
        chk(32'(sup), 32'h1);
        blk(sel + 2'h1, 1'b0);
        blk(sel, 1'b1);
        chk(32'(adat), 32'(crc_m));
        // channel interrupt flags, enables and priority
        wreg(ADDR_IRQ_EN, {12'h0, r[3:0], 16'h0});
        ev <= 4'hf;
        @(posedge clk);
        ev <= 4'h0;
        @(posedge clk);
        #1;
        chk(32'(irq), 32'(r[3:0]));
        rreg(ADDR_IRQ_FLAG, 32'h000f_0000);
        wreg(ADDR_IRQ_FLAG, 32'h0);
        rreg(ADDR_IRQ_FLAG, 32'h0);
        wreg(ADDR_IRQ_PRI, r);
        rreg(ADDR_IRQ_PRI, r & 32'h1f00_0000);
        chk(32'({pri, sub}), 32'(r[28:24]));
        wrap_up();
    end
endmodule : testbench
